// ---- hw/cfp_codec_frame_port.sv ----
// Summary of operation
// - Frames are 128 bit clocks: two 64-bit subframes, marked by frame sync.
// - Control bit picks internal bit clock: oscillator times 13, over 5 or 4.
// - Optionally the bit clock comes from an external clock pin.
// - All codec traffic rides in subframe 0; subframe 1 stays unused.
// - Frame sync is high one bit period, the 128th clock; frames abut.
// - Sync rise loads available audio and telecom words, sets valid flags.
// - Pending register request loads address, data and write-not-read bit.
// - Fields without fresh data resend last frame's value.
// - While enabled, frames run continuously even with nothing to send.
// - Bits 63:48 audio, 47 zero, 46:43 address, 42 write, 41:34 zero.
// - Bit 33 audio valid, 32 telecom valid, 31:16 telecom, 15:0 data.
// - Drive data on bit clock rise, sample incoming data on fall.
// - Shift out MSB first from bit 63, receive bit enters at bit 0.
// - After 64 clocks unpack received fields to FIFOs and result register.
// - During subframe 1 the shifter and unpack logic are held idle.
// - Serial output is low whenever not shifting data.
// - Four 8 by 16 FIFOs: audio/telecom transmit and receive.
// - A 21-bit request register and a 21-bit read result register.
// - 7-bit divisors load modulus counters on enable, decrement on bit clock.
// - After reset the port is off and its pins are all inputs.
`timescale 1ns/1ns
module cfp_codec_frame_port
	import cfp_pkg::*;
#(
	parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic i_serial_in_pin,
	input wire logic i_ext_bit_clk_pin,
	output logic [31:0] o_rd_data_r,
	output logic o_bit_clk_r,
	output logic o_bit_clk_oe_n_r,
	output logic o_frame_sync_r,
	output logic o_frame_sync_oe_n_r,
	output logic o_serial_out_r,
	output logic o_serial_out_oe_n_r
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic en;
	logic en_d_r;
	logic en_rise;
	logic rise_tick;
	logic fall_tick;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic load;
	logic unpack;
	logic shift_in;
	logic gated_r;
	logic [SUB_BITS-1:0] sh_r;
	logic [SUB_BITS-1:0] tx_frame;
	logic rx_meta_r;
	logic rx_sync_r;
	logic [SAMPLE_W-1:0] last_audio_r;
	logic [SAMPLE_W-1:0] last_tel_r;
	logic [REQ_W-1:0] last_req_r;
	logic [REQ_W-1:0] req_r;
	logic [REQ_W-1:0] req_fields;
	logic req_pending_r;
	logic inflight_r;
	logic [REQ_W-1:0] result_r;
	logic result_valid_r;
	logic [DIV_W-1:0] a_mod_r;
	logic [DIV_W-1:0] t_mod_r;
	logic [DIV_W-1:0] a_div;
	logic [DIV_W-1:0] t_div;
	logic [SAMPLE_W-1:0] atx_head, ttx_head, arx_head, trx_head;
	logic atx_full, atx_empty, ttx_full, ttx_empty;
	logic arx_full, arx_empty, trx_full, trx_empty;
	logic atx_push, ttx_push, arx_pop, trx_pop;
	logic arx_push, trx_push;
	logic wr_ctrl, wr_req, rd_result;
	logic [31:0] status;
	logic [31:0] rd_mux;

	function automatic logic cfp_hit(input logic stb, input logic [7:0] a,
		input logic [7:0] off);
		return stb && (a == off);
	endfunction

	function automatic logic [DIV_W-1:0] cfp_mod_next(
		input logic [DIV_W-1:0] cur, input logic [DIV_W-1:0] div);
		return (cur == '0) ? div : DIV_W'(cur - 1'b1);
	endfunction

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	assign en = ctrl_r[CTRL_EN_BIT];
	assign en_rise = en && !en_d_r;
	assign a_div = ctrl_r[CTRL_ADIV_LO +: DIV_W];
	assign t_div = ctrl_r[CTRL_TDIV_LO +: DIV_W];
	assign wr_ctrl = cfp_hit(i_wr_stb, i_addr, REG_CTRL);
	assign wr_req = cfp_hit(i_wr_stb, i_addr, REG_REQ);
	assign rd_result = cfp_hit(i_rd_stb, i_addr, REG_RESULT);
	assign atx_push = cfp_hit(i_wr_stb, i_addr, REG_AUDIO);
	assign ttx_push = cfp_hit(i_wr_stb, i_addr, REG_TELECOM);
	assign arx_pop = cfp_hit(i_rd_stb, i_addr, REG_AUDIO);
	assign trx_pop = cfp_hit(i_rd_stb, i_addr, REG_TELECOM);

	assign status = {1'b0, t_mod_r, 1'b0, a_mod_r, 6'h00, gated_r,
		result_valid_r, req_pending_r, trx_empty, arx_empty, ttx_empty,
		ttx_full, atx_empty, atx_full, en};

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (i_addr)
			REG_CTRL: rd_mux = ctrl_r;
			REG_STATUS: rd_mux = status;
			REG_AUDIO: rd_mux = arx_empty ? 32'h0 : {16'h0000, arx_head};
			REG_TELECOM: rd_mux = trx_empty ? 32'h0 : {16'h0000, trx_head};
			REG_REQ: rd_mux = {11'h000, req_r};
			REG_RESULT: rd_mux = {result_valid_r, 10'h000, result_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_rd_data_r <= 32'h0000_0000;
		end else begin
			o_rd_data_r <= i_rd_stb ? rd_mux : 32'h0000_0000;
		end
	end

	// Reset leaves the port disabled
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ctrl_r <= CTRL_RESET;
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= en;
			if (wr_ctrl) begin
				ctrl_r <= i_wr_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sample FIFOs and bit clock source
	// ----------------------------------------------------------------
	cfp_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH_P)) u_atx (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_push(atx_push),
		.i_push_data(i_wr_data[SAMPLE_W-1:0]), .i_pop(load && !atx_empty),
		.o_head(atx_head), .o_full(atx_full), .o_empty(atx_empty));
	cfp_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH_P)) u_ttx (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_push(ttx_push),
		.i_push_data(i_wr_data[SAMPLE_W-1:0]), .i_pop(load && !ttx_empty),
		.o_head(ttx_head), .o_full(ttx_full), .o_empty(ttx_empty));
	cfp_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH_P)) u_arx (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_push(arx_push),
		.i_push_data(sh_r[AUDIO_LO +: SAMPLE_W]), .i_pop(arx_pop),
		.o_head(arx_head), .o_full(arx_full), .o_empty(arx_empty));
	cfp_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH_P)) u_trx (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_push(trx_push),
		.i_push_data(sh_r[TEL_LO +: SAMPLE_W]), .i_pop(trx_pop),
		.o_head(trx_head), .o_full(trx_full), .o_empty(trx_empty));

	cfp_bclk_gen u_bclk (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_run(en),
		.i_fast(ctrl_r[CTRL_FAST_BIT]),
		.i_ext_sel(ctrl_r[CTRL_EXT_BIT]),
		.i_ext_clk_pin(i_ext_bit_clk_pin),
		.o_rise(rise_tick),
		.o_fall(fall_tick)
	);

	// ----------------------------------------------------------------
	// Frame timing
	// ----------------------------------------------------------------
	assign cnt_nxt = CNT_W'(cnt_r + 1'b1);
	assign load = en && rise_tick && (cnt_nxt == CNT_LAST);
	assign unpack = en && rise_tick && (cnt_nxt == CNT_SUB1);
	assign shift_in = en && fall_tick && !gated_r && (cnt_r < CNT_SUB1);

	// Count restarts one short of the sync slot so the first frame opens
	// with a sync pulse; afterwards it wraps freely, frames back to back
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !en) begin
			cnt_r <= CNT_START;
		end else if (rise_tick) begin
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !en) begin
			gated_r <= 1'b0;
		end else if (rise_tick) begin
			gated_r <= (cnt_nxt >= CNT_SUB1) && (cnt_nxt != CNT_LAST);
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rx_meta_r <= 1'b0;
			rx_sync_r <= 1'b0;
		end else begin
			rx_meta_r <= i_serial_in_pin;
			rx_sync_r <= rx_meta_r;
		end
	end

	// Disabled: enables high so the pins float as inputs
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !en) begin
			o_bit_clk_r <= 1'b0;
			o_frame_sync_r <= 1'b0;
			o_serial_out_r <= 1'b0;
			o_bit_clk_oe_n_r <= 1'b1;
			o_frame_sync_oe_n_r <= 1'b1;
			o_serial_out_oe_n_r <= 1'b1;
		end else begin
			o_bit_clk_oe_n_r <= 1'b0;
			o_frame_sync_oe_n_r <= 1'b0;
			o_serial_out_oe_n_r <= 1'b0;
			if (rise_tick) begin
				o_bit_clk_r <= 1'b1;
				o_frame_sync_r <= (cnt_nxt == CNT_LAST);
				o_serial_out_r <= (cnt_nxt < CNT_SUB1) ? sh_r[SUB_BITS-1] : 1'b0;
			end else if (fall_tick) begin
				o_bit_clk_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit frame assembly
	// ----------------------------------------------------------------
	assign req_fields = req_pending_r ? req_r : last_req_r;

	always_comb begin
		tx_frame = '0;
		tx_frame[AUDIO_LO +: SAMPLE_W] = atx_empty ? last_audio_r : atx_head;
		tx_frame[ADDR_LO +: ADDR_W] = req_fields[REQ_ADDR_LO +: ADDR_W];
		tx_frame[RW_BIT] = req_fields[REQ_RW_BIT];
		tx_frame[AV_BIT] = !atx_empty;
		tx_frame[TV_BIT] = !ttx_empty;
		tx_frame[TEL_LO +: SAMPLE_W] = ttx_empty ? last_tel_r : ttx_head;
		tx_frame[SAMPLE_W-1:0] = req_fields[SAMPLE_W-1:0];
	end

	// Shifter updates only in the sync slot and subframe 0
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			sh_r <= '0;
		end else if (load) begin
			sh_r <= tx_frame;
		end else if (shift_in) begin
			sh_r <= {sh_r[SUB_BITS-2:0], rx_sync_r};
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			last_audio_r <= '0;
			last_tel_r <= '0;
			last_req_r <= '0;
		end else if (load) begin
			last_audio_r <= tx_frame[AUDIO_LO +: SAMPLE_W];
			last_tel_r <= tx_frame[TEL_LO +: SAMPLE_W];
			last_req_r <= req_fields;
		end
	end

	// ----------------------------------------------------------------
	// Codec register request and result
	// ----------------------------------------------------------------
	// A software write in the same cycle as a load wins and stays pending
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			req_r <= '0;
			req_pending_r <= 1'b0;
		end else if (wr_req) begin
			req_r <= i_wr_data[REQ_W-1:0];
			req_pending_r <= 1'b1;
		end else if (load) begin
			req_pending_r <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			inflight_r <= 1'b0;
		end else if (load) begin
			// The frame carries the old request even when a new one lands
			inflight_r <= req_pending_r && !req_r[REQ_RW_BIT];
		end else if (unpack) begin
			inflight_r <= 1'b0;
		end
	end

	assign arx_push = unpack && sh_r[AV_BIT];
	assign trx_push = unpack && sh_r[TV_BIT];

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			result_r <= '0;
			result_valid_r <= 1'b0;
		end else if (unpack && inflight_r) begin
			result_r <= {sh_r[RW_BIT], sh_r[ADDR_LO +: ADDR_W],
				sh_r[SAMPLE_W-1:0]};
			result_valid_r <= 1'b1;
		end else if (rd_result) begin
			result_valid_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sample rate modulus counters
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			a_mod_r <= '0;
			t_mod_r <= '0;
		end else if (!en || en_rise) begin
			a_mod_r <= a_div;
			t_mod_r <= t_div;
		end else if (rise_tick) begin
			a_mod_r <= cfp_mod_next(a_mod_r, a_div);
			t_mod_r <= cfp_mod_next(t_mod_r, t_div);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	sequence frame_load_s;
		en && rise_tick && (cnt_nxt == CNT_LAST);
	endsequence

	sequence sub1_fall_s;
		en && fall_tick && (cnt_r > CNT_SUB1) && (cnt_r != CNT_LAST);
	endsequence

	// Pins follow the enable one cycle late
	sync_slot_only_a: assert property (
		o_frame_sync_r |-> en_d_r && (cnt_r == CNT_LAST))
		else $error("frame sync high outside the last bit slot");
	serial_idle_low_a: assert property (
		en && (cnt_r >= CNT_SUB1) && (cnt_r != CNT_LAST) && !load |=>
		!o_serial_out_r)
		else $error("serial output not low outside subframe 0");
	msb_first_a: assert property (
		en && rise_tick && (cnt_nxt == '0) |=> o_serial_out_r == $past(sh_r[63]))
		else $error("first bit sent is not bit 63");
	audio_flag_a: assert property (
		frame_load_s ##0 !atx_empty |=> sh_r[AV_BIT] &&
		sh_r[AUDIO_LO +: SAMPLE_W] == $past(atx_head))
		else $error("audio word or valid flag not loaded");
	zero_fields_a: assert property (
		frame_load_s |=> !sh_r[ZERO_BIT] && sh_r[PAD_HI:PAD_LO] == '0)
		else $error("fixed zero fields not zero");
	req_consumed_a: assert property (
		frame_load_s ##0 (req_pending_r && !wr_req) |=> !req_pending_r)
		else $error("loaded request still pending");
	rx_shift_a: assert property (
		shift_in |=> sh_r[0] == $past(rx_sync_r) && sh_r[63:1] == $past(sh_r[62:0]))
		else $error("receive bit not shifted in on fall");
	sub1_gated_a: assert property (
		sub1_fall_s |=> $stable(sh_r))
		else $error("shifter moved during subframe 1");
	unpack_push_a: assert property (
		unpack && sh_r[TV_BIT] && !trx_full |=> !trx_empty)
		else $error("telecom receive word not pushed");
	audio_push_a: assert property (
		unpack && sh_r[AV_BIT] && !arx_full |=> !arx_empty)
		else $error("audio receive word not pushed");
	pins_released_a: assert property (
		!en ##1 !en |-> o_serial_out_oe_n_r && o_frame_sync_oe_n_r &&
		o_bit_clk_oe_n_r)
		else $error("pins driven while disabled");
	mod_reload_a: assert property (
		en_rise |=> a_mod_r == $past(a_div) && t_mod_r == $past(t_div))
		else $error("modulus counters not loaded on enable");
	frame_run_a: assert property (
		frame_load_s ##1 (en && !wr_ctrl) [*2] |-> cnt_r == CNT_LAST)
		else $error("frame counter not at sync slot after load");

endmodule

// ---- hw/cfp_pkg.sv ----
package cfp_pkg;

	// ----------------------------------------------------------------
	// Clock rates
	// ----------------------------------------------------------------
	localparam longint SYS_CLK_HZ = 100_000_000;
	localparam longint OSC_HZ = 3_686_400;
	localparam longint PLL_MUL = 13;
	localparam longint DIV_SLOW = 5;
	localparam longint DIV_FAST = 4;
	localparam int NCO_W = 32;

	// Phase step per system clock; carries toggle the bit clock level
	function automatic logic [NCO_W-1:0] cfp_nco_inc(input longint div);
		longint num;
		num = 2 * OSC_HZ * PLL_MUL * (64'd1 << NCO_W);
		return NCO_W'(num / (div * SYS_CLK_HZ));
	endfunction

	localparam logic [NCO_W-1:0] NCO_INC_SLOW = cfp_nco_inc(DIV_SLOW);
	localparam logic [NCO_W-1:0] NCO_INC_FAST = cfp_nco_inc(DIV_FAST);

	// ----------------------------------------------------------------
	// Frame geometry and subframe 0 fields
	// ----------------------------------------------------------------
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] CNT_LAST = 7'h7f;
	localparam logic [CNT_W-1:0] CNT_SUB1 = 7'h40;
	localparam logic [CNT_W-1:0] CNT_START = 7'h7e;
	localparam int SUB_BITS = 64;
	localparam int AUDIO_LO = 48;
	localparam int ZERO_BIT = 47;
	localparam int ADDR_LO = 43;
	localparam int RW_BIT = 42;
	localparam int PAD_HI = 41;
	localparam int PAD_LO = 34;
	localparam int AV_BIT = 33;
	localparam int TV_BIT = 32;
	localparam int TEL_LO = 16;
	localparam int SAMPLE_W = 16;
	localparam int ADDR_W = 4;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_AUDIO = 8'h08;
	localparam logic [7:0] REG_TELECOM = 8'h0c;
	localparam logic [7:0] REG_REQ = 8'h10;
	localparam logic [7:0] REG_RESULT = 8'h14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_EXT_BIT = 2;
	localparam int CTRL_ADIV_LO = 8;
	localparam int CTRL_TDIV_LO = 16;
	localparam int DIV_W = 7;
	localparam int REQ_W = 21;
	localparam int REQ_RW_BIT = 20;
	localparam int REQ_ADDR_LO = 16;
	localparam int RESULT_VALID_BIT = 31;

endpackage

// ---- hw/cfp_fifo.sv ----
`timescale 1ns/1ns
module cfp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_push,
	input wire logic [WIDTH-1:0] i_push_data,
	input wire logic i_pop,
	output logic [WIDTH-1:0] o_head,
	output logic o_full,
	output logic o_empty
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic do_push;
	logic do_pop;

	function automatic logic [PW-1:0] cfp_ptr_inc(input logic [PW-1:0] p);
		return (p == LAST_IDX) ? '0 : PW'(p + 1'b1);
	endfunction

	assign o_full = (count_r == FULL_CNT);
	assign o_empty = (count_r == '0);
	assign o_head = mem_r[rd_ptr_r];
	// Overflowing pushes and empty pops are dropped
	assign do_push = i_push && !o_full;
	assign do_pop = i_pop && !o_empty;

	always_ff @(posedge i_sys_clk) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= i_push_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= cfp_ptr_inc(wr_ptr_r);
			end
			if (do_pop) begin
				rd_ptr_r <= cfp_ptr_inc(rd_ptr_r);
			end
			if (do_push && !do_pop) begin
				count_r <= CW'(count_r + 1'b1);
			end else if (do_pop && !do_push) begin
				count_r <= CW'(count_r - 1'b1);
			end
		end
	end

endmodule

// ---- hw/cfp_bclk_gen.sv ----
`timescale 1ns/1ns
module cfp_bclk_gen
	import cfp_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_run,
	input wire logic i_fast,
	input wire logic i_ext_sel,
	input wire logic i_ext_clk_pin,
	output logic o_rise,
	output logic o_fall
);
	logic [NCO_W-1:0] acc_r;
	logic [NCO_W:0] acc_sum;
	logic phase_r;
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_prev_r;

	// ----------------------------------------------------------------
	// Internal oscillator path
	// ----------------------------------------------------------------
	// Fractional accumulator: edges jitter by one system clock, but the
	// long-run rate is the multiplied-and-divided oscillator rate
	assign acc_sum = {1'b0, acc_r} +
		{1'b0, (i_fast ? NCO_INC_FAST : NCO_INC_SLOW)};

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !i_run) begin
			acc_r <= '0;
			phase_r <= 1'b0;
		end else begin
			acc_r <= acc_sum[NCO_W-1:0];
			if (acc_sum[NCO_W]) begin
				phase_r <= !phase_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// External clock path
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			ext_meta_r <= i_ext_clk_pin;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !i_run) begin
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else if (i_ext_sel) begin
			o_rise <= ext_sync_r && !ext_prev_r;
			o_fall <= !ext_sync_r && ext_prev_r;
		end else begin
			o_rise <= acc_sum[NCO_W] && !phase_r;
			o_fall <= acc_sum[NCO_W] && phase_r;
		end
	end

endmodule

// ---- dv/cfp_codec_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Codec side of the frame link
// ----------------------------------------
module cfp_codec_model (
	input wire logic i_bit_clk,
	input wire logic i_frame_sync,
	input wire logic i_serial_out,
	input wire logic [63:0] i_reply,
	output logic o_serial_in,
	output logic [63:0] o_heard,
	output logic [7:0] o_frame_cnt
);
	int slot = 64;
	logic [63:0] sh = '0;
	initial begin
		o_serial_in = 1'b0;
		o_heard = '0;
		o_frame_cnt = '0;
	end
	// Drives low outside subframe 0 rather than floating
	always @(posedge i_bit_clk) begin
		o_serial_in <= (slot < 64) ? i_reply[63 - slot] : 1'b0;
	end
	// Sync sampled on the fall, where it is steady
	always @(negedge i_bit_clk) begin
		if (i_frame_sync) begin
			slot = 0;
		end else if (slot < 64) begin
			sh = {sh[62:0], i_serial_out};
			slot = slot + 1;
			if (slot == 64) begin
				o_heard <= sh;
				o_frame_cnt <= o_frame_cnt + 8'h01;
			end
		end
	end
endmodule

// ---- dv/cfp_codec_frame_port_tb.sv ----
`timescale 1ns/1ns
module cfp_codec_frame_port_tb
	import cfp_pkg::*;
;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_wr_stb = 1'b0;
	logic i_rd_stb = 1'b0;
	logic ext = 1'b0;
	logic [7:0] i_addr = '0;
	logic [31:0] i_wr_data = '0;
	logic [31:0] rdata, d;
	logic sin, bclk, bclk_oe, fs, fs_oe, so, so_oe;
	logic [63:0] heard;
	logic [7:0] fcnt;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int ediv = 0;
	int rises = 0;
	int c, b, w, i;
	localparam logic [63:0] REPLY = {16'h5a5a, 1'b0, 4'h3, 1'b0, 8'h00,
		1'b1, 1'b1, 16'h0f0f, 16'h7777};

	cfp_codec_frame_port dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
		.i_rd_stb(i_rd_stb), .i_serial_in_pin(sin),
		.i_ext_bit_clk_pin(ext), .o_rd_data_r(rdata),
		.o_bit_clk_r(bclk), .o_bit_clk_oe_n_r(bclk_oe),
		.o_frame_sync_r(fs), .o_frame_sync_oe_n_r(fs_oe),
		.o_serial_out_r(so), .o_serial_out_oe_n_r(so_oe));
	cfp_codec_model codec (.i_bit_clk(bclk), .i_frame_sync(fs),
		.i_serial_out(so), .i_reply(REPLY), .o_serial_in(sin),
		.o_heard(heard), .o_frame_cnt(fcnt));

	// ----------------------------------------
	// Clock, external bit clock, watchdog
	// ----------------------------------------
	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge bclk) rises++;
	// External source at 200 ns period, free running
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		ediv <= (ediv == 9) ? 0 : ediv + 1;
		if (ediv == 9) begin
			ext <= ~ext;
		end
		if (cycles == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wr_data <= v;
		i_wr_stb <= 1'b1;
		@(posedge i_sys_clk);
		i_wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_sys_clk);
		i_rd_stb <= 1'b0;
		@(negedge i_sys_clk);
		v = rdata;
	endtask
	task automatic wait_fr();
		logic [7:0] t;
		t = fcnt + 8'h01;
		while (fcnt !== t) @(posedge i_sys_clk);
	endtask
	// Settle delay makes the coincident bit clock rise count once
	task automatic measure(output int cyc, output int bits, output int wid);
		int c0, b0;
		@(posedge fs);
		#1;
		chk("sync on clk rise", 64'(bclk), 64'd1);
		c0 = cycles;
		b0 = rises;
		@(negedge fs);
		wid = cycles - c0;
		@(posedge fs);
		#1;
		cyc = cycles - c0;
		bits = rises - b0;
	endtask
	function automatic logic [63:0] fr(input logic [15:0] au,
		input logic [3:0] ad, input logic rw, input logic av,
		input logic tv, input logic [15:0] te, input logic [15:0] da);
		return {au, 1'b0, ad, rw, 8'h00, av, tv, te, da};
	endfunction

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		@(posedge i_sys_clk);
		#1;
		chk("oe_n idle", {bclk_oe, fs_oe, so_oe}, 3'b111);
		chk("pins low", {bclk, fs, so}, 3'b000);
		rd(REG_CTRL, d);
		chk("ctrl", d, CTRL_RESET);
		rd(8'h20, d);
		chk("unmapped", d, 32'h0);
		rd(REG_STATUS, d);
		chk("status", d & 32'h1ff, 32'h74);
		$display("test reset done");

		wr(REG_AUDIO, 32'ha5c3);
		wr(REG_TELECOM, 32'h1234);
		wr(REG_REQ, 32'h15beef);
		wr(REG_CTRL, 32'h0c0c00);
		rd(REG_STATUS, d);
		chk("modulus", d & 32'h7f7f0000, 32'h0c0c0000);
		wr(REG_CTRL, 32'h0c0c01);
		wait_fr();
		chk("frame 1", heard, fr(16'ha5c3, 4'h5, 1'b1, 1'b1, 1'b1,
			16'h1234, 16'hbeef));
		chk("oe_n on", {bclk_oe, fs_oe, so_oe}, 3'b000);
		rd(REG_STATUS, d);
		chk("consumed", d & 32'h86, 32'h04);
		$display("test load done");

		wr(REG_REQ, 32'h090000);
		wait_fr();
		chk("frame 2", heard, fr(16'ha5c3, 4'h9, 1'b0, 1'b0, 1'b0,
			16'h1234, 16'h0000));
		repeat (30) @(posedge i_sys_clk);
		#1;
		chk("out idle", so, 1'b0);
		rd(REG_RESULT, d);
		chk("result", d, 32'h8003_7777);
		rd(REG_AUDIO, d);
		chk("audio rx", d, 32'h5a5a);
		rd(REG_TELECOM, d);
		chk("telecom rx", d, 32'h0f0f);
		wait_fr();
		chk("frame 3", heard, fr(16'ha5c3, 4'h9, 1'b0, 1'b0, 1'b0,
			16'h1234, 16'h0000));
		$display("test transfer done");

		measure(c, b, w);
		chk("bits", 64'(b), 64'd128);
		chk("slow len", 64'(c > 1332 && c < 1339), 64'd1);
		chk("sync width", 64'(w > 8 && w < 13), 64'd1);
		wr(REG_CTRL, 32'h0c0c03);
		measure(c, b, w);
		measure(c, b, w);
		chk("fast len", 64'(c > 1064 && c < 1073), 64'd1);
		wr(REG_CTRL, 32'h0c0c05);
		measure(c, b, w);
		measure(c, b, w);
		chk("ext len", 64'(c > 2555 && c < 2565), 64'd1);
		chk("ext bits", 64'(b), 64'd128);
		$display("test rates done");

		wr(REG_CTRL, 32'h0);
		repeat (40) @(posedge i_sys_clk);
		for (i = 0; i < 9; i++) begin
			wr(REG_AUDIO, 32'(i));
		end
		rd(REG_STATUS, d);
		chk("atx full", d & 32'h6, 32'h2);
		$display("test fifo done");
		report_and_stop();
	end
endmodule
